// ### common/rst_seq_pkg.sv
// package: constants, types and register layout for the reset and brown-out sequencer
// Summary of operation
// R1: nine reset sources each reset the device
// R2: hold reset while supply below power-on level
// R3: power-up delay nominally 64 ms after event
// R4: internal reset held while delay timer runs
// R5: delay enable is active low configuration bit
// R6: delay starts after power-on and brown-out release
// R7: two-bit mode: on, sleep-off, software, off
// R8: one bit selects brown-out trip level
// R9: brown-out only after dip exceeds filter time
// R10: mode 11 detector always on, start waits
// R11: mode 11 active in sleep, no wake delay
// R12: mode 10 on awake, off asleep, start waits
// R13: mode 10 wake-up waits for detector ready
// R14: mode 01 software enable, start not delayed
// R15: mode 01 protection once ready, status shown
// R16: forced-on detector ready before execution starts
// R17: bit 7 enables detector only in mode 01
// R18: bit 6 keeps reference on in 10/01
// R19: status bit 0 shows detector active
// R20: bits 7/6 reset 1/0 on power events only
// R21: ten clocks after pin release, execution starts
// R22: start needs timer done and pin released
// R23: delay counted on free-running low-frequency clock
// R24: ready after settling count, clears on disable
// R25: bits 5 to 1 read zero, ignore writes
package rst_seq_pkg;

   // ------------------------------------------------------------
   // register map
   // ------------------------------------------------------------
   localparam logic [11:0] BROWNOUT_CONTROL_STATUS_ADDR = 12'h000;
   localparam int          SW_ENABLE_BIT                = 7;
   localparam int          FAST_START_BIT               = 6;
   localparam int          READY_BIT                    = 0;
   localparam logic        SW_ENABLE_RESET              = 1'b1;
   localparam logic        FAST_START_RESET             = 1'b0;

   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int PWRUP_DELAY_MS     = 64;
   localparam int LF_CLK_HZ          = 31000;
   // lf ticks for the nominal delay, rounded down as a longest time
   localparam int PWRUP_LF_TICKS     = PWRUP_DELAY_MS * LF_CLK_HZ / 1000;
   localparam int EXEC_START_CYCLES  = 10;
   localparam int FILTER_CYCLES_DEF  = 8;
   localparam int SETTLE_CYCLES_DEF  = 16;

   typedef enum logic [1:0] {
      MODE_OFF      = 2'b00,
      MODE_SOFTWARE = 2'b01,
      MODE_SLEEP_OFF= 2'b10,
      MODE_ALWAYS   = 2'b11
   } brownout_mode_t;

   typedef enum logic [2:0] {
      ST_POWER   = 3'b000,
      ST_PWRUP   = 3'b001,
      ST_PIN     = 3'b010,
      ST_DELAY   = 3'b011,
      ST_RUN     = 3'b100,
      ST_WAKE    = 3'b101
   } seq_state_t;

   typedef struct packed {
      logic watchdog_reset;
      logic reset_instruction;
      logic stack_overflow;
      logic stack_underflow;
      logic program_exit;
      logic low_power_brownout_reset;
   } soft_sources_t;

endpackage : rst_seq_pkg

// ### hdl/reset_and_brownout_sequencer.sv
// module: reset merge, power-up delay and brown-out control with an apb register
`timescale 1ns/1ps
module reset_and_brownout_sequencer #(
   parameter int PWRUP_TICKS   = rst_seq_pkg::PWRUP_LF_TICKS,
   parameter int FILTER_CYCLES = rst_seq_pkg::FILTER_CYCLES_DEF,
   parameter int SETTLE_CYCLES = rst_seq_pkg::SETTLE_CYCLES_DEF
) (
   input  wire logic                       pclk,
   input  wire logic                       presetn,
   input  wire logic                       psel,
   input  wire logic                       penable,
   input  wire logic                       pwrite,
   input  wire logic [11:0]                paddr,
   input  wire logic [31:0]                pwdata,
   input  wire logic [3:0]                 pstrb,
   output logic      [31:0]                prdata,
   output logic                            pready,
   output logic                            pslverr,
   input  wire logic                       lf_clk_pin,
   input  wire logic                       supply_below_por,
   input  wire logic                       supply_below_threshold,
   input  wire logic                       external_reset_pin_n,
   input  wire logic                       external_reset_pin_enable,
   input  wire logic                       power_up_delay_enable_n,
   input  wire logic [1:0]                 brownout_mode,
   input  wire logic                       brownout_level_select,
   input  wire logic                       sleep_request,
   input  wire rst_seq_pkg::soft_sources_t soft_sources,
   output logic                            device_reset,
   output logic                            cpu_run,
   output logic                            brownout_detector_enable,
   output logic                            brownout_level,
   output logic                            reference_force_on,
   output logic                            brownout_event
);

   // ------------------------------------------------------------
   // pin synchronisers: three stages, change once 2nd and 3rd agree
   // ------------------------------------------------------------
   localparam int NSYNC = 5;
   logic [NSYNC-1:0] async_in;
   logic [NSYNC-1:0] s1_r;
   logic [NSYNC-1:0] s2_r;
   logic [NSYNC-1:0] s3_r;
   logic [NSYNC-1:0] filt_r;

   assign async_in = {lf_clk_pin, supply_below_por, supply_below_threshold, external_reset_pin_n, sleep_request};

   genvar gi;
   generate
      for (gi = 0; gi < NSYNC; gi++) begin : g_sync
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               s1_r[gi]   <= 1'b0;
               s2_r[gi]   <= 1'b0;
               s3_r[gi]   <= 1'b0;
               filt_r[gi] <= 1'b0;
            end else begin
               s1_r[gi] <= async_in[gi];
               s2_r[gi] <= s1_r[gi];
               s3_r[gi] <= s2_r[gi];
               if (s2_r[gi] == s3_r[gi]) begin
                  filt_r[gi] <= s3_r[gi];
               end
            end
         end
      end
   endgenerate

   logic lf_s;
   logic por_low;
   logic below_thr;
   logic pin_n;
   logic asleep;
   assign lf_s      = filt_r[4];
   assign por_low   = filt_r[3];
   assign below_thr = filt_r[2];
   assign pin_n     = filt_r[1];
   assign asleep    = filt_r[0];

   // ------------------------------------------------------------
   // register bits
   // ------------------------------------------------------------
   logic sw_enable_r;
   logic fast_start_r;
   logic ready_r;
   logic power_event;
   logic wr_hit;
   logic rd_hit;
   logic addr_ok;

   assign addr_ok = (paddr == rst_seq_pkg::BROWNOUT_CONTROL_STATUS_ADDR);
   assign wr_hit  = psel && penable && pwrite && addr_ok && pstrb[0];
   assign rd_hit  = psel && !penable && !pwrite && addr_ok;

   // power-on or brown-out: besides presetn, the only events that restore the control bits
   logic bor_r;
   assign power_event = por_low || bor_r;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sw_enable_r  <= rst_seq_pkg::SW_ENABLE_RESET;
         fast_start_r <= rst_seq_pkg::FAST_START_RESET;
      end else if (power_event) begin
         sw_enable_r  <= rst_seq_pkg::SW_ENABLE_RESET;   // see R20
         fast_start_r <= rst_seq_pkg::FAST_START_RESET;  // see R20
      end else if (wr_hit) begin
         sw_enable_r  <= pwdata[rst_seq_pkg::SW_ENABLE_BIT];
         fast_start_r <= pwdata[rst_seq_pkg::FAST_START_BIT];
      end
   end

   // ------------------------------------------------------------
   // detector enable by mode
   // ------------------------------------------------------------
   rst_seq_pkg::brownout_mode_t mode;
   logic det_en_nxt;
   logic waits_ready;
   assign mode = rst_seq_pkg::brownout_mode_t'(brownout_mode);  // see R7

   always_comb begin
      case (mode)
         rst_seq_pkg::MODE_ALWAYS:    det_en_nxt = 1'b1;             // see R10 R11
         rst_seq_pkg::MODE_SLEEP_OFF: det_en_nxt = !asleep;          // see R12
         rst_seq_pkg::MODE_SOFTWARE:  det_en_nxt = sw_enable_r;      // see R14 R17
         default:                     det_en_nxt = 1'b0;
      endcase
   end

   // start-up waits for ready in every mode except software and off
   assign waits_ready = (mode == rst_seq_pkg::MODE_ALWAYS) || (mode == rst_seq_pkg::MODE_SLEEP_OFF); // see R14

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         brownout_detector_enable <= 1'b0;
         brownout_level           <= 1'b0;
         reference_force_on       <= 1'b0;
      end else begin
         brownout_detector_enable <= det_en_nxt;
         brownout_level           <= brownout_level_select;  // see R8
         reference_force_on       <= fast_start_r &&
                                     ((mode == rst_seq_pkg::MODE_SLEEP_OFF) ||
                                      (mode == rst_seq_pkg::MODE_SOFTWARE)); // see R18
      end
   end

   // ------------------------------------------------------------
   // detector settling and ready flag
   // ------------------------------------------------------------
   logic [15:0] settle_r;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         settle_r <= 16'h0000;
         ready_r  <= 1'b0;
      end else if (!det_en_nxt) begin
         settle_r <= 16'h0000;                               // see R24
         ready_r  <= 1'b0;
      end else if (settle_r >= 16'(SETTLE_CYCLES - 1)) begin
         ready_r  <= 1'b1;                                   // see R24 R19
      end else begin
         settle_r <= settle_r + 16'h0001;
      end
   end

   // ------------------------------------------------------------
   // brown-out filter: short dips never reach the reset
   // ------------------------------------------------------------
   logic [15:0] dip_r;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dip_r <= 16'h0000;
         bor_r <= 1'b0;
      end else if (!(ready_r && below_thr)) begin
         dip_r <= 16'h0000;
         bor_r <= 1'b0;
      end else if (dip_r >= 16'(FILTER_CYCLES)) begin
         bor_r <= 1'b1;                                      // see R9 R15
      end else begin
         dip_r <= dip_r + 16'h0001;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         brownout_event <= 1'b0;
      end else begin
         brownout_event <= bor_r;
      end
   end

   // ------------------------------------------------------------
   // power-up delay on the low-frequency clock
   // ------------------------------------------------------------
   logic        lf_d_r;
   logic        lf_tick;
   logic [15:0] pwrup_r;
   logic        pwrup_done_r;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lf_d_r <= 1'b0;
      end else begin
         lf_d_r <= lf_s;
      end
   end
   assign lf_tick = lf_s && !lf_d_r;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pwrup_r      <= 16'h0000;
         pwrup_done_r <= 1'b0;
      end else if (power_event) begin
         pwrup_r      <= 16'h0000;                           // see R6
         pwrup_done_r <= 1'b0;
      end else if (power_up_delay_enable_n) begin
         pwrup_done_r <= 1'b1;                               // see R5
      end else if (pwrup_r >= 16'(PWRUP_TICKS)) begin
         pwrup_done_r <= 1'b1;                               // see R3 R23
      end else if (lf_tick) begin
         pwrup_r <= pwrup_r + 16'h0001;
      end
   end

   // ------------------------------------------------------------
   // start sequencer
   // ------------------------------------------------------------
   rst_seq_pkg::seq_state_t state_r;
   logic [3:0] exec_r;
   logic       soft_any;
   logic       pin_held;
   assign soft_any = |soft_sources;                          // see R1
   assign pin_held = external_reset_pin_enable && !pin_n;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= rst_seq_pkg::ST_POWER;
         exec_r  <= 4'h0;
      end else if (power_event) begin
         state_r <= rst_seq_pkg::ST_POWER;                   // see R2 R1
         exec_r  <= 4'h0;
      end else if (soft_any || pin_held) begin
         state_r <= rst_seq_pkg::ST_PIN;                     // see R1
         exec_r  <= 4'h0;
      end else begin
         case (state_r)
            rst_seq_pkg::ST_POWER: state_r <= rst_seq_pkg::ST_PWRUP;
            rst_seq_pkg::ST_PWRUP: begin
               if (pwrup_done_r && (!waits_ready || (ready_r && !below_thr))) begin
                  state_r <= rst_seq_pkg::ST_PIN;            // see R4 R10 R12 R16
               end
            end
            rst_seq_pkg::ST_PIN: begin
               exec_r  <= 4'h0;
               state_r <= rst_seq_pkg::ST_DELAY;             // see R22
            end
            rst_seq_pkg::ST_DELAY: begin
               if (exec_r >= 4'(rst_seq_pkg::EXEC_START_CYCLES - 1)) begin
                  state_r <= rst_seq_pkg::ST_RUN;            // see R21
               end else begin
                  exec_r <= exec_r + 4'h1;
               end
            end
            rst_seq_pkg::ST_RUN: begin
               if (asleep) begin
                  state_r <= rst_seq_pkg::ST_WAKE;
               end
            end
            rst_seq_pkg::ST_WAKE: begin
               // only mode 10 holds wake-up for the re-enabled detector
               if (!asleep && (mode != rst_seq_pkg::MODE_SLEEP_OFF || ready_r)) begin
                  state_r <= rst_seq_pkg::ST_RUN;            // see R11 R13
               end
            end
            default: state_r <= rst_seq_pkg::ST_POWER;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         device_reset <= 1'b1;
         cpu_run      <= 1'b0;
      end else begin
         device_reset <= (state_r != rst_seq_pkg::ST_RUN) && (state_r != rst_seq_pkg::ST_WAKE); // see R4
         cpu_run      <= (state_r == rst_seq_pkg::ST_RUN);
      end
   end

   // ------------------------------------------------------------
   // apb slave: zero wait states, unmapped addresses give pslverr
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel && !penable;
         pslverr <= psel && !penable && !addr_ok;
         if (rd_hit) begin
            prdata <= {24'h00_0000, sw_enable_r, fast_start_r, 5'h00, ready_r}; // see R25 R19
         end else begin
            prdata <= 32'h0000_0000;
         end
      end
   end

endmodule : reset_and_brownout_sequencer

// ### verif/rst_seq_props.sv
// checker: port-level properties of the reset and brown-out sequencer
`timescale 1ns/1ps
module rst_seq_props #(
   parameter int PWRUP_TICKS   = 4,
   parameter int FILTER_CYCLES = 8,
   parameter int SETTLE_CYCLES = 16
) (
   input wire logic                       pclk,
   input wire logic                       presetn,
   input wire logic                       supply_below_por,
   input wire logic                       supply_below_threshold,
   input wire logic                       external_reset_pin_n,
   input wire logic                       external_reset_pin_enable,
   input wire logic [1:0]                 brownout_mode,
   input wire logic                       brownout_level_select,
   input wire logic                       sleep_request,
   input wire rst_seq_pkg::soft_sources_t soft_sources,
   input wire logic                       device_reset,
   input wire logic                       cpu_run,
   input wire logic                       brownout_detector_enable,
   input wire logic                       brownout_level,
   input wire logic                       reference_force_on,
   input wire logic                       brownout_event
);
   // ------------------------------------------------------------
   // pin windows of seven cycles cover the four-flop synchroniser plus state and output flops
   // ------------------------------------------------------------
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_por_hold: assert property (supply_below_por [*7] |-> device_reset)
      else $error("reset released while supply low");
   a_pin_hold: assert property ((external_reset_pin_enable && !external_reset_pin_n) [*7] |-> device_reset)
      else $error("reset released while pin held");
   a_soft_src: assert property ((soft_sources != '0) [*3] |-> device_reset)
      else $error("soft source did not reset");
   a_run_excl: assert property (cpu_run |-> !device_reset)
      else $error("running while in reset");
   a_mode_off: assert property ((brownout_mode == 2'b00) [*6] |-> !brownout_detector_enable)
      else $error("detector on in off mode");
   a_mode_on: assert property ((brownout_mode == 2'b11) [*6] |-> brownout_detector_enable)
      else $error("detector off in always-on mode");
   a_ref_idle: assert property ((brownout_mode == 2'b00 || brownout_mode == 2'b11) [*6] |-> !reference_force_on)
      else $error("reference forced in wrong mode");
   a_level_copy: assert property ($stable(brownout_level_select) [*6] |-> brownout_level == brownout_level_select)
      else $error("trip level not followed");
   a_sleep_off: assert property ((sleep_request && brownout_mode == 2'b10) [*6] |-> !brownout_detector_enable)
      else $error("detector on during sleep");
   a_dip_filter: assert property ($rose(brownout_event) |->
      $past(supply_below_threshold, 6) && $past(supply_below_threshold, 9))
      else $error("brown-out raised on short dip");
   a_start_gap: assert property ($rose(cpu_run) |-> $past(external_reset_pin_n, 10) || !$past(external_reset_pin_enable, 10))
      else $error("execution started too soon after pin");
   c_run: cover property ($rose(cpu_run));
   c_event: cover property ($rose(brownout_event));
   c_sleep: cover property (sleep_request && brownout_mode == 2'b10);
endmodule : rst_seq_props

bind reset_and_brownout_sequencer rst_seq_props #(.PWRUP_TICKS(PWRUP_TICKS), .FILTER_CYCLES(FILTER_CYCLES),
   .SETTLE_CYCLES(SETTLE_CYCLES)) u_props (.pclk, .presetn, .supply_below_por, .supply_below_threshold,
   .external_reset_pin_n, .external_reset_pin_enable, .brownout_mode, .brownout_level_select, .sleep_request,
   .soft_sources, .device_reset, .cpu_run, .brownout_detector_enable, .brownout_level, .reference_force_on,
   .brownout_event);

// ### verif/tb.sv
// testbench: register access, start-up, modes, sleep, brown-out and reset sources
`timescale 1ns/1ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin error_cnt++; \
   $display("CHECK FAILED t=%0t got %h exp %h", $time, (a), (e)); end end
module tb;
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, lf_clk_pin = 0;
   logic        supply_below_por = 1, supply_below_threshold = 0, external_reset_pin_n = 1;
   logic        external_reset_pin_enable = 1, power_up_delay_enable_n = 0, brownout_level_select = 0;
   logic        sleep_request = 0, pready, pslverr, device_reset, cpu_run, brownout_detector_enable;
   logic        brownout_level, reference_force_on, brownout_event, en;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000, prdata;
   logic [3:0]  pstrb = 4'h0;
   logic [1:0]  brownout_mode = 2'b11;
   logic [32:0] exp_q[$];
   rst_seq_pkg::soft_sources_t soft_sources = '0;
   int          error_cnt = 0, total_checks = 0, n;

   reset_and_brownout_sequencer #(.PWRUP_TICKS(4)) dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .pstrb, .prdata, .pready, .pslverr, .lf_clk_pin, .supply_below_por, .supply_below_threshold,
      .external_reset_pin_n, .external_reset_pin_enable, .power_up_delay_enable_n, .brownout_mode,
      .brownout_level_select, .sleep_request, .soft_sources, .device_reset, .cpu_run, .brownout_detector_enable,
      .brownout_level, .reference_force_on, .brownout_event);

   always #25 pclk = ~pclk;
   // slow clock of 16 pclk periods keeps the shortened power-up delay visible
   always #400 lf_clk_pin = ~lf_clk_pin;

   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [32:0] e);
      @(posedge pclk);
      psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d; pstrb <= 4'hf;
      if (!wr) exp_q.push_back(e);
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      psel <= 1'b0; penable <= 1'b0;
   endtask : apb

   task automatic wait_run(output int cnt);
      cnt = 0;
      while (cpu_run !== 1'b1 && cnt < 3000) begin
         @(posedge pclk);
         cnt++;
      end
   endtask : wait_run

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : end_of_test

   always @(posedge pclk) begin
      if (psel && penable && pready === 1'b1 && !pwrite) begin
         if (exp_q.size() == 0) `CHK(1'b0, 1'b1)
         else `CHK({pslverr, prdata}, exp_q.pop_front())
      end
   end

   initial begin
      #(50 * 20000);
      error_cnt++;
      end_of_test();
   end

   initial begin
      void'($urandom(32'h4778));
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      repeat (10) @(posedge pclk);
      `CHK(device_reset, 1'b1)
      supply_below_por <= 1'b0;
      wait_run(n);
      `CHK(n >= 48, 1'b1)
      `CHK(device_reset, 1'b0)
      $display("power-up test done");
      apb(0, 12'h000, 0, {1'b0, 32'h0000_0081});
      apb(1, 12'h000, 32'h0000_00ff, 0);
      apb(0, 12'h000, 0, {1'b0, 32'h0000_00c1});
      apb(1, {10'($urandom_range(1, 1023)), 2'b00}, 32'h0000_0000, 0);
      apb(0, {10'($urandom_range(1, 1023)), 2'b00}, 0, {1'b1, 32'h0000_0000});
      apb(0, 12'h000, 0, {1'b0, 32'h0000_00c1});
      $display("register test done");
      for (int m = 0; m < 4; m++) begin
         for (int s = 0; s < 2; s++) begin
            apb(1, 12'h000, {24'h0, s[0], 7'h40}, 0);
            brownout_mode <= m[1:0];
            brownout_level_select <= 1'($urandom);
            repeat (30) @(posedge pclk);
            en = (m == 3) || (m == 2) || (m == 1 && s == 1);
            `CHK(brownout_detector_enable, en)
            `CHK(reference_force_on, 1'(m == 1 || m == 2))
            `CHK(brownout_level, brownout_level_select)
            apb(0, 12'h000, 0, {1'b0, 24'h0, s[0], 6'h20, en});
         end
      end
      $display("mode test done");
      brownout_mode <= 2'b10;
      sleep_request <= 1'b1;
      repeat (30) @(posedge pclk);
      `CHK(brownout_detector_enable, 1'b0)
      `CHK(cpu_run, 1'b0)
      sleep_request <= 1'b0;
      wait_run(n);
      `CHK(n >= 16, 1'b1)
      brownout_mode <= 2'b11;
      repeat (30) @(posedge pclk);
      sleep_request <= 1'b1;
      repeat (30) @(posedge pclk);
      `CHK(brownout_detector_enable, 1'b1)
      sleep_request <= 1'b0;
      wait_run(n);
      `CHK(n < 16, 1'b1)
      $display("sleep test done");
      apb(1, 12'h000, 32'h0000_0040, 0);
      supply_below_threshold <= 1'b1;
      repeat (3) @(posedge pclk);
      supply_below_threshold <= 1'b0;
      repeat (20) @(posedge pclk);
      `CHK(brownout_event, 1'b0)
      supply_below_threshold <= 1'b1;
      repeat (30) @(posedge pclk);
      `CHK(brownout_event, 1'b1)
      `CHK(device_reset, 1'b1)
      supply_below_threshold <= 1'b0;
      apb(0, 12'h000, 0, {1'b0, 32'h0000_0081});
      wait_run(n);
      `CHK(n >= 48, 1'b1)
      $display("brown-out test done");
      external_reset_pin_n <= 1'b0;
      repeat (100) @(posedge pclk);
      `CHK(device_reset, 1'b1)
      external_reset_pin_n <= 1'b1;
      wait_run(n);
      `CHK(n >= 10 && n <= 20, 1'b1)
      for (int i = 0; i < 6; i++) begin
         soft_sources <= rst_seq_pkg::soft_sources_t'(6'h01 << i);
         repeat (3) @(posedge pclk);
         `CHK(device_reset, 1'b1)
         soft_sources <= '0;
         wait_run(n);
         `CHK(n <= 20, 1'b1)
      end
      $display("source test done");
      apb(1, 12'h000, 32'h0000_0000, 0);
      power_up_delay_enable_n <= 1'b1;
      supply_below_por <= 1'b1;
      repeat (10) @(posedge pclk);
      supply_below_por <= 1'b0;
      wait_run(n);
      `CHK(n < 40, 1'b1)
      apb(0, 12'h000, 0, {1'b0, 32'h0000_0081});
      $display("bypass test done");
      end_of_test();
   end
endmodule : tb
